// ---- design/bsf_pkg.sv ----
// Shared constants of the boot sector flash host controller.
package bsf_pkg;
   localparam int CLK_NS = 10;
   // Strobe width for read and write cycles on the flash pins.
   localparam int STROBE_NS = 70;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   // Width of the hardware reset pulse driven to the flash.
   localparam int RESET_NS = 500;
   localparam int RESET_CYC = (RESET_NS + CLK_NS - 1) / CLK_NS;
   localparam int SEQ_DEPTH = 6;
   // Register byte offsets on the control bus.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RDATA = 8'h08;
   localparam logic [7:0] OFS_SEQ = 8'h10;
   // Control register fields.
   localparam int CTRL_GO = 0;
   localparam int CTRL_POLL = 1;
   localparam int CTRL_WORD = 2;
   localparam int CTRL_READ = 3;
   localparam int CTRL_HWRST = 4;
   localparam int CTRL_URGENT = 5;
   localparam int CTRL_LEN_LSB = 8;
   // Status register fields.
   localparam int STAT_BUSY = 0;
   localparam int STAT_READY = 1;
   localparam int STAT_TOG6 = 2;
   localparam int STAT_TOG2 = 3;
   localparam int STAT_PEND = 4;
   // Status bit positions in the flash data word.
   localparam int PROGRESS_BIT = 6;
   localparam int ERASE_SECT_BIT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [15:0] OE_WORD = 16'hffff;
   localparam logic [15:0] OE_BYTE = 16'h80ff;
   localparam logic [15:0] OE_BYTE_RD = 16'h8000;
endpackage

// ---- design/bsf_pin_cycle.sv ----
// One asynchronous read or write cycle on the flash pins.
`timescale 1ns/1ps
module bsf_pin_cycle #(
   parameter int STROBE_CYC = bsf_pkg::STROBE_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        clkEn,
   input  wire logic        start,
   input  wire logic        isWrite,
   input  wire logic        wordMode,
   input  wire logic [20:0] addr,
   input  wire logic [15:0] wdata,
   input  wire logic [15:0] dqIn,
   output logic             done,
   output logic [15:0]      rdata,
   output logic             ceN,
   output logic             weN,
   output logic             oeN,
   output logic [19:0]      pinAddr,
   output logic [15:0]      dqOut,
   output logic [15:0]      dqOe
);
   initial
   begin
      if (STROBE_CYC < 1 || STROBE_CYC > 255)
         $error("STROBE_CYC out of range");
   end

   typedef enum logic [3:0] {
      P_IDLE = 4'h1, P_SETUP = 4'h2, P_STROBE = 4'h4, P_HOLD = 4'h8
   } bsf_pstate_t;

   bsf_pstate_t state_q, state_d;
   logic [7:0]  cnt_q, cnt_d;
   logic        wr_q, wr_d;
   logic        ceN_d, weN_d, oeN_d;
   logic [19:0] addr_d;
   logic [15:0] dqOut_d, dqOe_d, rdata_d;

   assign done = (state_q == P_HOLD) && clkEn;

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      wr_d = wr_q;
      ceN_d = ceN;
      weN_d = weN;
      oeN_d = oeN;
      addr_d = pinAddr;
      dqOut_d = dqOut;
      dqOe_d = dqOe;
      rdata_d = rdata;
      case (state_q)
         P_IDLE:
         begin
            if (start)
            begin
               state_d = P_SETUP;
               ceN_d = 1'b0;
               wr_d = isWrite;
               // In byte mode the top data line carries the low address bit.
               addr_d = wordMode ? addr[19:0] : addr[20:1];
               dqOut_d = wordMode ? wdata : {addr[0], 7'h00, wdata[7:0]};
               if (isWrite)
                  dqOe_d = wordMode ? bsf_pkg::OE_WORD : bsf_pkg::OE_BYTE;
               else
                  dqOe_d = wordMode ? 16'h0000 : bsf_pkg::OE_BYTE_RD;
            end
         end
         P_SETUP:
         begin
            state_d = P_STROBE;
            cnt_d = 8'(STROBE_CYC - 1);
            if (wr_q)
               weN_d = 1'b0;
            else
               oeN_d = 1'b0;
         end
         P_STROBE:
         begin
            if (cnt_q == 8'h00)
            begin
               state_d = P_HOLD;
               weN_d = 1'b1;
               oeN_d = 1'b1;
               if (!wr_q)
                  rdata_d = wordMode ? dqIn : {8'h00, dqIn[7:0]};
            end
            else
               cnt_d = cnt_q - 8'h01;
         end
         P_HOLD:
         begin
            state_d = P_IDLE;
            ceN_d = 1'b1;
            dqOe_d = 16'h0000;
         end
         default: state_d = P_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         state_q <= P_IDLE;
         cnt_q <= 8'h00;
         wr_q <= 1'b0;
         ceN <= 1'b1;
         weN <= 1'b1;
         oeN <= 1'b1;
         pinAddr <= 20'h00000;
         dqOut <= 16'h0000;
         dqOe <= 16'h0000;
         rdata <= 16'h0000;
      end
      else if (clkEn)
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         wr_q <= wr_d;
         ceN <= ceN_d;
         weN <= weN_d;
         oeN <= oeN_d;
         pinAddr <= addr_d;
         dqOut <= dqOut_d;
         dqOe <= dqOe_d;
         rdata <= rdata_d;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   standby_idle_a: assert property (
      (state_q == P_IDLE) |-> ceN && weN && oeN)
      else $error("flash selected while cycle engine idle");
   no_contention_a: assert property (
      !oeN |-> ((dqOe & 16'h7fff) == 16'h0000))
      else $error("data lines driven while flash output enabled");
endmodule

// ---- design/bsf_host_ctrl.sv ----
// Host controller driving a boot sector flash, commanded over AXI4-Lite.
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// Operation
// - Host sends commands as write cycles into the command register.
// - In unlock bypass a program takes two writes, not four.
// - Host may suspend erase, access other sectors, then resume it.
// - Host can place the flash in low-power standby via control pins.
module bsf_host_ctrl #(
   parameter int SEQ_DEPTH = bsf_pkg::SEQ_DEPTH,
   parameter int RESET_CYC = bsf_pkg::RESET_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        clkEn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             flashCeN,
   output logic             flashWeN,
   output logic             flashOeN,
   output logic             flashResetN,
   output logic             flashByteN,
   output logic [19:0]      flashAddr,
   output logic [15:0]      flashDqOut,
   output logic [15:0]      flashDqOe,
   input  wire logic [15:0] flashDqIn,
   input  wire logic        opCompleteFlagPin
);
   initial
   begin
      if (SEQ_DEPTH < 2 || SEQ_DEPTH > 7
          || RESET_CYC < 1 || RESET_CYC > 65535)
         $error("bsf_host_ctrl parameters out of range");
   end

   typedef enum logic [6:0] {
      S_IDLE = 7'h01, S_SEQ = 7'h02, S_SEQW = 7'h04, S_RDW = 7'h08,
      S_POLL = 7'h10, S_POLLW = 7'h20, S_RST = 7'h40
   } bsf_state_t;

   // Bus slave state.
   logic        awHeld_q, awHeld_d, wHeld_q, wHeld_d;
   logic [7:0]  awAddr_q, awAddr_d;
   logic [31:0] wData_q, wData_d;
   logic [3:0]  wStrb_q, wStrb_d;
   logic        bvalid_d, rvalid_d;
   logic [1:0]  bresp_d, rresp_d;
   logic [31:0] rdata_d;
   logic        wrEn, wrOk, wrSeq;
   logic [7:0]  wrAddr, wrOff, rdOff;
   logic [31:0] wrData;
   logic [3:0]  wrStrb;

   // Control state.
   bsf_state_t  state_q, state_d;
   logic [2:0]  idx_q, idx_d, seqLen_q, seqLen_d;
   logic        poll_q, poll_d, word_q, word_d, pend_q, pend_d;
   logic        prevOk_q, prevOk_d, tog6_q, tog6_d, tog2_q, tog2_d;
   logic [15:0] prev_q, prev_d;
   logic [15:0] rstCnt_q, rstCnt_d;
   logic        rstN_d;
   logic [20:0] seqAddr_q [SEQ_DEPTH];
   logic [15:0] seqData_q [SEQ_DEPTH];
   logic        ctlGo, busy, cycStart, cycWrite, cycDone;
   logic [20:0] cycAddr;
   logic [15:0] pinData;
   logic [2:0]  lenIn;

   assign busy = (state_q != S_IDLE);
   assign flashByteN = word_q;
   assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // Address and data may come in either order; the write acts on both.
   always_comb
   begin
      awHeld_d = awHeld_q || (s_axi_awvalid && s_axi_awready);
      wHeld_d = wHeld_q || (s_axi_wvalid && s_axi_wready);
      awAddr_d = awHeld_q ? awAddr_q : s_axi_awaddr;
      wData_d = wHeld_q ? wData_q : s_axi_wdata;
      wStrb_d = wHeld_q ? wStrb_q : s_axi_wstrb;
      wrEn = awHeld_d && wHeld_d && !s_axi_bvalid;
      wrAddr = awAddr_d;
      wrData = wData_d;
      wrStrb = wStrb_d;
      wrOff = wrAddr - bsf_pkg::OFS_SEQ;
      wrSeq = (wrAddr >= bsf_pkg::OFS_SEQ) && (wrAddr[1:0] == 2'h0)
              && (wrOff[7:3] < 5'(SEQ_DEPTH));
      // Partial writes are refused so a half-written command is never issued.
      wrOk = (wrStrb == 4'hf)
             && (wrSeq || wrAddr == bsf_pkg::OFS_CTRL);
      bvalid_d = s_axi_bvalid && !s_axi_bready;
      bresp_d = s_axi_bresp;
      if (wrEn)
      begin
         awHeld_d = 1'b0;
         wHeld_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wrOk ? bsf_pkg::RESP_OKAY : bsf_pkg::RESP_SLVERR;
      end
      rvalid_d = s_axi_rvalid && !s_axi_rready;
      rresp_d = s_axi_rresp;
      rdata_d = s_axi_rdata;
      rdOff = s_axi_araddr - bsf_pkg::OFS_SEQ;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_d = 1'b1;
         rresp_d = bsf_pkg::RESP_OKAY;
         rdata_d = 32'h00000000;
         if (s_axi_araddr == bsf_pkg::OFS_CTRL)
         begin
            rdata_d[bsf_pkg::CTRL_POLL] = poll_q;
            rdata_d[bsf_pkg::CTRL_WORD] = word_q;
            rdata_d[bsf_pkg::CTRL_LEN_LSB +: 3] = seqLen_q;
         end
         else if (s_axi_araddr == bsf_pkg::OFS_STATUS)
         begin
            rdata_d[bsf_pkg::STAT_BUSY] = busy;
            rdata_d[bsf_pkg::STAT_READY] = opCompleteFlagPin;
            rdata_d[bsf_pkg::STAT_TOG6] = tog6_q;
            rdata_d[bsf_pkg::STAT_TOG2] = tog2_q;
            rdata_d[bsf_pkg::STAT_PEND] = pend_q;
         end
         else if (s_axi_araddr == bsf_pkg::OFS_RDATA)
            rdata_d[15:0] = pinData;
         else if (s_axi_araddr >= bsf_pkg::OFS_SEQ && s_axi_araddr[1:0] == 2'h0
                  && rdOff[7:3] < 5'(SEQ_DEPTH))
         begin
            if (rdOff[2])
               rdata_d[15:0] = seqData_q[rdOff[5:3]];
            else
               rdata_d[20:0] = seqAddr_q[rdOff[5:3]];
         end
         else
            rresp_d = bsf_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h00000000;
      end
      else if (clkEn)
      begin
         awHeld_q <= awHeld_d;
         wHeld_q <= wHeld_d;
         awAddr_q <= awAddr_d;
         wData_q <= wData_d;
         wStrb_q <= wStrb_d;
         s_axi_bvalid <= bvalid_d;
         s_axi_bresp <= bresp_d;
         s_axi_rvalid <= rvalid_d;
         s_axi_rresp <= rresp_d;
         s_axi_rdata <= rdata_d;
      end
   end

   // Command sequence table: one address and one data word per entry, each set by its own bus write.
   for (genvar g = 0; g < SEQ_DEPTH; g++)
   begin : gEntry
      logic [20:0] a_d;
      logic [15:0] d_d;
      always_comb
      begin
         a_d = seqAddr_q[g];
         d_d = seqData_q[g];
         if (wrEn && wrOk && wrSeq && wrOff[5:3] == 3'(g))
         begin
            if (wrOff[2])
               d_d = wrData[15:0];
            else
               a_d = wrData[20:0];
         end
      end
      always_ff @(posedge clk_sys)
      begin
         if (srst)
         begin
            seqAddr_q[g] <= 21'h000000;
            seqData_q[g] <= 16'h0000;
         end
         else if (clkEn)
         begin
            seqAddr_q[g] <= a_d;
            seqData_q[g] <= d_d;
         end
      end
   end

   assign ctlGo = wrEn && wrOk && (wrAddr == bsf_pkg::OFS_CTRL)
                  && wrData[bsf_pkg::CTRL_GO];
   assign lenIn = (wrData[bsf_pkg::CTRL_LEN_LSB +: 3] > 3'(SEQ_DEPTH))
                  ? 3'(SEQ_DEPTH) : wrData[bsf_pkg::CTRL_LEN_LSB +: 3];

   always_comb
   begin
      state_d = state_q;
      idx_d = idx_q;
      seqLen_d = seqLen_q;
      poll_d = poll_q;
      word_d = word_q;
      pend_d = pend_q;
      prevOk_d = prevOk_q;
      prev_d = prev_q;
      tog6_d = tog6_q;
      tog2_d = tog2_q;
      rstCnt_d = rstCnt_q;
      rstN_d = flashResetN;
      cycStart = 1'b0;
      cycWrite = 1'b0;
      cycAddr = seqAddr_q[idx_q];
      // A go that arrives while busy is dropped unless marked urgent.
      if (ctlGo && (!busy || wrData[bsf_pkg::CTRL_URGENT]))
      begin
         seqLen_d = lenIn;
         poll_d = wrData[bsf_pkg::CTRL_POLL];
         if (!busy)
            word_d = wrData[bsf_pkg::CTRL_WORD];
         if (busy)
            pend_d = 1'b1;
      end
      case (state_q)
         S_IDLE:
         begin
            idx_d = 3'h0;
            if (ctlGo && wrData[bsf_pkg::CTRL_HWRST])
            begin
               state_d = S_RST;
               rstN_d = 1'b0;
               rstCnt_d = 16'(RESET_CYC - 1);
            end
            else if (ctlGo && wrData[bsf_pkg::CTRL_READ])
            begin
               cycStart = 1'b1;
               cycAddr = seqAddr_q[0];
               state_d = S_RDW;
            end
            else if ((ctlGo && lenIn != 3'h0) || (pend_q && seqLen_q != 3'h0))
            begin
               state_d = S_SEQ;
               pend_d = 1'b0;
               tog6_d = 1'b0;
               tog2_d = 1'b0;
            end
            else
               pend_d = 1'b0;
         end
         S_SEQ:
         begin
            cycStart = 1'b1;
            cycWrite = 1'b1;
            state_d = S_SEQW;
         end
         S_SEQW:
         begin
            if (cycDone)
            begin
               if (idx_q == seqLen_q - 3'h1)
               begin
                  prevOk_d = 1'b0;
                  state_d = poll_q ? S_POLL : S_IDLE;
               end
               else
               begin
                  idx_d = idx_q + 3'h1;
                  state_d = S_SEQ;
               end
            end
         end
         S_RDW:
         begin
            if (cycDone)
               state_d = S_IDLE;
         end
         S_POLL:
         begin
            // A pending command sequence, such as a suspend, may be slipped in between status reads.
            if (pend_q)
            begin
               pend_d = 1'b0;
               idx_d = 3'h0;
               state_d = S_SEQ;
            end
            else
            begin
               cycStart = 1'b1;
               state_d = S_POLLW;
            end
         end
         S_POLLW:
         begin
            if (cycDone)
            begin
               // Done once the progress bit stops toggling and the pin is ready.
               if (prevOk_q && opCompleteFlagPin
                   && prev_q[bsf_pkg::PROGRESS_BIT]
                   == pinData[bsf_pkg::PROGRESS_BIT])
                  state_d = S_IDLE;
               else
                  state_d = S_POLL;
               if (prevOk_q && prev_q[bsf_pkg::PROGRESS_BIT]
                   != pinData[bsf_pkg::PROGRESS_BIT])
                  tog6_d = 1'b1;
               if (prevOk_q && prev_q[bsf_pkg::ERASE_SECT_BIT]
                   != pinData[bsf_pkg::ERASE_SECT_BIT])
                  tog2_d = 1'b1;
               prev_d = pinData;
               prevOk_d = 1'b1;
            end
         end
         S_RST:
         begin
            if (rstCnt_q == 16'h0000)
            begin
               rstN_d = 1'b1;
               state_d = S_IDLE;
            end
            else
               rstCnt_d = rstCnt_q - 16'h0001;
         end
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         state_q <= S_IDLE;
         idx_q <= 3'h0;
         seqLen_q <= 3'h0;
         poll_q <= 1'b0;
         word_q <= 1'b1;
         pend_q <= 1'b0;
         prevOk_q <= 1'b0;
         prev_q <= 16'h0000;
         tog6_q <= 1'b0;
         tog2_q <= 1'b0;
         rstCnt_q <= 16'h0000;
         flashResetN <= 1'b1;
      end
      else if (clkEn)
      begin
         state_q <= state_d;
         idx_q <= idx_d;
         seqLen_q <= seqLen_d;
         poll_q <= poll_d;
         word_q <= word_d;
         pend_q <= pend_d;
         prevOk_q <= prevOk_d;
         prev_q <= prev_d;
         tog6_q <= tog6_d;
         tog2_q <= tog2_d;
         rstCnt_q <= rstCnt_d;
         flashResetN <= rstN_d;
      end
   end

   bsf_pin_cycle u_cycle (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .clkEn    (clkEn),
      .start    (cycStart),
      .isWrite  (cycWrite),
      .wordMode (word_q),
      .addr     (cycAddr),
      .wdata    (seqData_q[idx_q]),
      .dqIn     (flashDqIn),
      .done     (cycDone),
      .rdata    (pinData),
      .ceN      (flashCeN),
      .weN      (flashWeN),
      .oeN      (flashOeN),
      .pinAddr  (flashAddr),
      .dqOut    (flashDqOut),
      .dqOe     (flashDqOe)
   );

   // Helper: counts falling write strobes on the pin since the sequence began.
   logic [3:0] weFalls_q;
   logic       weSeen_q;
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         weFalls_q <= 4'h0;
         weSeen_q <= 1'b1;
      end
      else if (clkEn)
      begin
         weSeen_q <= flashWeN;
         if (state_q != S_SEQ && state_q != S_SEQW)
            weFalls_q <= 4'h0;
         else if (weSeen_q && !flashWeN)
            weFalls_q <= weFalls_q + 4'h1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst || !clkEn);

   cmd_as_write_a: assert property (
      (state_q == S_SEQ) |-> ##2 (!flashWeN && flashOeN && !flashCeN))
      else $error("command step did not become a write cycle");
   seq_length_a: assert property (
      (state_q == S_SEQW && cycDone && idx_q == seqLen_q - 3'h1)
      |-> weFalls_q == 4'(seqLen_q))
      else $error("write strobes differ from sequence length");
   suspend_slip_a: assert property (
      (state_q == S_POLL && pend_q) |=> (state_q == S_SEQ && !pend_q))
      else $error("urgent sequence not issued between polls");
   poll_guard_a: assert property (
      (state_q == S_POLLW && !pend_q && !ctlGo)
      |=> (state_q inside {S_POLLW, S_POLL, S_IDLE}))
      else $error("new sequence started before completion");
   poll_done_a: assert property (
      (state_q == S_POLLW && cycDone && !opCompleteFlagPin)
      |=> state_q == S_POLL)
      else $error("poll finished while flash busy");

   cov_seq_poll_c: cover property (
      (state_q == S_POLLW) ##1 (state_q == S_IDLE));
   cov_suspend_c: cover property (
      (state_q == S_POLL && pend_q) ##1 (state_q == S_SEQ));
   cov_read_c: cover property ((state_q == S_RDW) ##1 (state_q == S_IDLE));
   cov_reset_c: cover property ((state_q == S_RST) ##1 (state_q == S_IDLE));
endmodule

// ---- tb/bsf_flash_model.sv ----
// Behavioural flash device answering the host controller pins.
`timescale 1ns/1ps
module bsf_flash_model #(
   parameter int BUSY = 40
) (
   input  wire logic        clk_sys,
   input  wire logic        flashCeN,
   input  wire logic        flashWeN,
   input  wire logic        flashOeN,
   input  wire logic        flashResetN,
   input  wire logic [19:0] flashAddr,
   input  wire logic [15:0] flashDqOut,
   output logic [15:0]      flashDqIn,
   output logic             opCompleteFlagPin
);
   logic [19:0] capAddr = 20'h0;
   logic [15:0] capData = 16'h0;
   logic [15:0] dqQ     = 16'h0;
   logic        weQ     = 1'b1;
   logic        tog     = 1'b0;
   int          bsyCnt  = 0;
   int          rstSeen = 0;
   int          wrCnt   = 0;
   assign flashDqIn = dqQ;
   assign opCompleteFlagPin = (bsyCnt == 0);
   always @(posedge clk_sys)
   begin
      weQ <= flashWeN;
      if (!flashResetN)
      begin
         bsyCnt <= 0;
         rstSeen <= rstSeen + 1;
      end
      else if (!flashCeN && flashWeN && !weQ)
      begin
         // Latches close on the rising write strobe, as a real part does.
         capAddr <= flashAddr;
         capData <= flashDqOut;
         wrCnt <= wrCnt + 1;
         bsyCnt <= BUSY;
      end
      else if (bsyCnt != 0)
         bsyCnt <= bsyCnt - 1;
      if (!flashCeN && !flashOeN)
      begin
         tog <= ~tog;
         // Both status bits change from read to read while busy.
         dqQ <= (bsyCnt != 0)
                ? {9'h0, tog, 3'h0, tog, 2'h0}
                : capData;
      end
      else
         // A released bus shows a changing pattern, never the last value.
         dqQ <= ~dqQ;
   end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench of the flash host controller over AXI4-Lite.
`timescale 1ns/1ps
module testbench;
   localparam int RST_CYC = 4;
   logic        clk_sys = 1'b0, srst = 1'b1, clkEn = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, val;
   logic        flashCeN, flashWeN, flashOeN, flashResetN, flashByteN;
   logic        opCompleteFlagPin;
   logic [19:0] flashAddr;
   logic [15:0] flashDqOut, flashDqOe, flashDqIn;
   int          failures = 0, checked = 0, base;
   always #5 clk_sys = ~clk_sys;
   bsf_host_ctrl #(.RESET_CYC(RST_CYC)) u_dut (.clk_sys, .srst, .clkEn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .flashCeN, .flashWeN, .flashOeN, .flashResetN,
      .flashByteN, .flashAddr, .flashDqOut, .flashDqOe, .flashDqIn,
      .opCompleteFlagPin);
   bsf_flash_model u_flash (.clk_sys, .flashCeN, .flashWeN, .flashOeN,
      .flashResetN, .flashAddr, .flashDqOut, .flashDqIn, .opCompleteFlagPin);
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Handshake seen at the falling edge is the one the next rising edge takes.
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      logic ah, wh, bh;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(negedge clk_sys);
         ah = s_axi_awvalid && s_axi_awready;
         wh = s_axi_wvalid && s_axi_wready;
         bh = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge clk_sys);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
      end
      while (!bh);
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      logic ah, rh;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(negedge clk_sys);
         ah = s_axi_arvalid && s_axi_arready;
         rh = s_axi_rvalid;
         val = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge clk_sys);
         if (ah) s_axi_arvalid <= 1'b0;
      end
      while (!rh);
      s_axi_rready <= 1'b0;
   endtask
   task automatic wait_idle();
      do
         axr(bsf_pkg::OFS_STATUS);
      while (val[bsf_pkg::STAT_BUSY] !== 1'b0);
   endtask
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clk_sys);
      srst <= 1'b0;
      axr(8'h04);
      chk("idle status", 32'h2, val);
      axr(8'h0c);
      chk("unmapped rresp", 32'h2, {30'h0, resp});
      axw(8'h10, 32'h0, 4'h3);
      chk("partial bresp", 32'h2, {30'h0, resp});
      axw(8'h10, 32'h0000abcd, 4'hf);
      axw(8'h14, 32'h00005a30, 4'hf);
      axw(8'h00, 32'h00000107, 4'hf);
      wait_idle();
      chk("poll status", 32'he, val);
      chk("cmd addr", 32'habcd, {12'h0, u_flash.capAddr});
      chk("cmd data", 32'h5a30, {16'h0, u_flash.capData});
      axw(8'h00, 32'h0000000d, 4'hf);
      wait_idle();
      axr(8'h08);
      chk("array read", 32'h5a30, val);
      base = u_flash.wrCnt;
      axw(8'h10, 32'h00000aaa, 4'hf);
      axw(8'h14, 32'h000000a0, 4'hf);
      axw(8'h18, 32'h00000003, 4'hf);
      axw(8'h1c, 32'h00000030, 4'hf);
      axw(8'h00, 32'h00000203, 4'hf);
      wait_idle();
      chk("bypass writes", 32'd2, u_flash.wrCnt - base);
      chk("byte addr", 32'h1, {12'h0, u_flash.capAddr});
      chk("byte data", 32'h8030, {16'h0, u_flash.capData & 16'h80ff});
      // A plain go while busy is dropped; an urgent one runs between polls.
      base = u_flash.wrCnt;
      axw(8'h00, 32'h00000103, 4'hf);
      axw(8'h00, 32'h00000103, 4'hf);
      axw(8'h00, 32'h00000123, 4'hf);
      wait_idle();
      chk("urgent writes", 32'd2, u_flash.wrCnt - base);
      axr(8'h00);
      chk("ctrl readback", 32'h102, val);
      val = {flashDqOe, 12'h0, flashByteN, flashCeN, flashWeN, flashOeN};
      chk("idle pins", 32'h7, val);
      // Freezing the clock enable mid pulse stretches it by the frozen edges.
      base = u_flash.rstSeen;
      axw(8'h00, 32'h00000015, 4'hf);
      clkEn <= 1'b0;
      repeat (6) @(posedge clk_sys);
      clkEn <= 1'b1;
      wait_idle();
      chk("reset width", RST_CYC + 6, u_flash.rstSeen - base);
      test_done();
   end
   initial
   begin
      #300us;
      failures++;
      test_done();
   end
endmodule
